/* File: code_unit_cfg.svh */
// constants for the bus condition code unit: special register addresses, bit positions,
// reset values and the condition codes themselves
// assumes nothing beyond being included once per compilation unit
`ifndef CODE_UNIT_CFG_SVH
`define CODE_UNIT_CFG_SVH

`define CTRL_ADDR 8'hC0
`define CODE_ADDR 8'hC1
`define CTRL_RESET 8'h00
`define CODE_RESET 8'h00
`define CTRL_BUSY_BIT 7
`define CTRL_EN_BIT 6
`define CTRL_BEGIN_BIT 5
`define CTRL_END_BIT 4
`define CTRL_SI_BIT 3
`define CTRL_AA_BIT 2

`define CODE_START 8'h08
`define CODE_RSTART 8'h10
`define CODE_MT_SLA_ACK 8'h18
`define CODE_MT_SLA_NACK 8'h20
`define CODE_MT_DATA_ACK 8'h28
`define CODE_MT_DATA_NACK 8'h30
`define CODE_ARB_LOST 8'h38
`define CODE_MR_SLA_ACK 8'h40
`define CODE_MR_SLA_NACK 8'h48
`define CODE_MR_DATA_ACK 8'h50
`define CODE_MR_DATA_NACK 8'h58
`define CODE_SR_OWN 8'h60
`define CODE_SR_ARB_OWN 8'h68
`define CODE_SR_GC 8'h70
`define CODE_SR_ARB_GC 8'h78
`define CODE_SR_DATA_ACK 8'h80
`define CODE_SR_DATA_NACK 8'h88
`define CODE_SR_GC_DATA_ACK 8'h90
`define CODE_SR_GC_DATA_NACK 8'h98
`define CODE_SR_STOP 8'hA0
`define CODE_ST_OWN 8'hA8
`define CODE_ST_ARB_OWN 8'hB0
`define CODE_ST_DATA_ACK 8'hB8
`define CODE_ST_DATA_NACK 8'hC0
`define CODE_ST_LAST_ACK 8'hC8
`define CODE_TIMEOUT 8'hD0
`define CODE_BUS_ERROR 8'h00
`define CODE_IDLE 8'hF8

`endif

/* File: code_unit_pkg.sv */
// types shared by the condition code unit and its link-side port
// assumes the constants header is compiled alongside
package code_unit_pkg;

    typedef enum logic [4:0] {
        st_start, st_rstart, st_mt_sla_ack, st_mt_sla_nack, st_mt_data_ack,
        st_mt_data_nack, st_arb_lost, st_mr_sla_ack, st_mr_sla_nack, st_mr_data_ack,
        st_mr_data_nack, st_sr_own, st_sr_arb_own, st_sr_gc, st_sr_arb_gc,
        st_sr_data_ack, st_sr_data_nack, st_sr_gc_data_ack, st_sr_gc_data_nack,
        st_sr_stop, st_st_own, st_st_arb_own, st_st_data_ack, st_st_data_nack,
        st_st_last_ack, st_timeout, st_bus_error, st_idle
    } state_t;

    typedef enum logic [3:0] {
        ev_start_sent, ev_rstart_sent, ev_addr_sent, ev_data_sent, ev_data_recv,
        ev_arb_lost, ev_addressed, ev_stop_seen, ev_timeout, ev_bus_error
    } ev_kind_t;

    typedef enum logic [1:0] {m_none, m_own, m_gc} match_t;

    typedef struct packed {
        ev_kind_t kind;
        logic ack;
        logic read;
        match_t match;
    } link_event_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage

/* File: level_sync.sv */
// two-flop synchroniser for a group of independent levels
// assumes each bit is a level that stays put for several destination clocks
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic [WIDTH-1:0] in_level,
    output logic [WIDTH-1:0] out_level
);

    // no reset: this also carries the reset itself into the other domain
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock) begin
        meta_q <= in_level;
        out_level <= meta_q;
    end

endmodule

`default_nettype wire

/* File: link_event_port.sv */
// link-side port: holds each bus event from the shift engine and flips a toggle for it,
// and drives the acknowledge level on the data line
// assumes the shift engine on the link clock pulses ev_valid once per event
`timescale 1ns/1ps
`default_nettype none

module link_event_port (
    input wire logic link_clock,
    input wire logic link_nrst,
    input wire logic ev_valid,
    input wire code_unit_pkg::link_event_t ev_in,
    input wire logic ack_slot,
    input wire logic aa_level,
    output code_unit_pkg::link_event_t ev_hold,
    output logic ev_toggle,
    output logic sda_o,
    output logic sda_oe
);

    // held until the next event, so the system side may sample it after the toggle
    always_ff @(posedge link_clock) begin
        if (!link_nrst) begin
            ev_hold <= '0;
            ev_toggle <= 1'b0;
        end else if (ev_valid) begin
            ev_hold <= ev_in;
            ev_toggle <= ~ev_toggle;
        end
    end

    // low only while acknowledging; a not-acknowledge just releases the line
    always_ff @(posedge link_clock) begin
        if (!link_nrst) begin
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            sda_oe <= ack_slot & aa_level;
        end
    end

endmodule

`default_nettype wire

/* File: condition_code_unit.sv */
// condition code unit: keeps the protocol state, its 8-bit code and the serial event flag,
// and the control bits software uses to steer the shift engine
// assumes the special register port and a link-side shift engine clocked by link_clock
`timescale 1ns/1ps
`default_nettype none
`include "code_unit_cfg.svh"

module condition_code_unit (
    input wire logic clock,
    input wire logic nrst,
    input wire code_unit_pkg::sfr_req_t sfr,
    output logic [7:0] sfr_rdata,
    input wire logic link_clock,
    input wire logic link_ev_valid,
    input wire code_unit_pkg::link_event_t link_ev,
    input wire logic link_ack_slot,
    output logic sda_o,
    output logic sda_oe,
    output logic begin_request_link,
    output logic end_request_link,
    output logic serial_event,
    output logic [7:0] bus_condition_code
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // state to code mapping and mode tests

    function automatic logic [7:0] code_of(input code_unit_pkg::state_t s);
        case (s)
            code_unit_pkg::st_start: code_of = `CODE_START;
            code_unit_pkg::st_rstart: code_of = `CODE_RSTART;
            code_unit_pkg::st_mt_sla_ack: code_of = `CODE_MT_SLA_ACK;
            code_unit_pkg::st_mt_sla_nack: code_of = `CODE_MT_SLA_NACK;
            code_unit_pkg::st_mt_data_ack: code_of = `CODE_MT_DATA_ACK;
            code_unit_pkg::st_mt_data_nack: code_of = `CODE_MT_DATA_NACK;
            code_unit_pkg::st_arb_lost: code_of = `CODE_ARB_LOST;
            code_unit_pkg::st_mr_sla_ack: code_of = `CODE_MR_SLA_ACK;
            code_unit_pkg::st_mr_sla_nack: code_of = `CODE_MR_SLA_NACK;
            code_unit_pkg::st_mr_data_ack: code_of = `CODE_MR_DATA_ACK;
            code_unit_pkg::st_mr_data_nack: code_of = `CODE_MR_DATA_NACK;
            code_unit_pkg::st_sr_own: code_of = `CODE_SR_OWN;
            code_unit_pkg::st_sr_arb_own: code_of = `CODE_SR_ARB_OWN;
            code_unit_pkg::st_sr_gc: code_of = `CODE_SR_GC;
            code_unit_pkg::st_sr_arb_gc: code_of = `CODE_SR_ARB_GC;
            code_unit_pkg::st_sr_data_ack: code_of = `CODE_SR_DATA_ACK;
            code_unit_pkg::st_sr_data_nack: code_of = `CODE_SR_DATA_NACK;
            code_unit_pkg::st_sr_gc_data_ack: code_of = `CODE_SR_GC_DATA_ACK;
            code_unit_pkg::st_sr_gc_data_nack: code_of = `CODE_SR_GC_DATA_NACK;
            code_unit_pkg::st_sr_stop: code_of = `CODE_SR_STOP;
            code_unit_pkg::st_st_own: code_of = `CODE_ST_OWN;
            code_unit_pkg::st_st_arb_own: code_of = `CODE_ST_ARB_OWN;
            code_unit_pkg::st_st_data_ack: code_of = `CODE_ST_DATA_ACK;
            code_unit_pkg::st_st_data_nack: code_of = `CODE_ST_DATA_NACK;
            code_unit_pkg::st_st_last_ack: code_of = `CODE_ST_LAST_ACK;
            code_unit_pkg::st_timeout: code_of = `CODE_TIMEOUT;
            code_unit_pkg::st_bus_error: code_of = `CODE_BUS_ERROR;
            default: code_of = `CODE_IDLE;
        endcase
    endfunction

    function automatic logic is_master(input code_unit_pkg::state_t s);
        is_master = (s inside {code_unit_pkg::st_start, code_unit_pkg::st_rstart,
            code_unit_pkg::st_mt_sla_ack, code_unit_pkg::st_mt_sla_nack,
            code_unit_pkg::st_mt_data_ack, code_unit_pkg::st_mt_data_nack,
            code_unit_pkg::st_mr_sla_ack, code_unit_pkg::st_mr_sla_nack,
            code_unit_pkg::st_mr_data_ack, code_unit_pkg::st_mr_data_nack});
    endfunction

    function automatic logic is_slave(input code_unit_pkg::state_t s);
        is_slave = (s inside {code_unit_pkg::st_sr_own, code_unit_pkg::st_sr_arb_own,
            code_unit_pkg::st_sr_gc, code_unit_pkg::st_sr_arb_gc,
            code_unit_pkg::st_sr_data_ack, code_unit_pkg::st_sr_data_nack,
            code_unit_pkg::st_sr_gc_data_ack, code_unit_pkg::st_sr_gc_data_nack,
            code_unit_pkg::st_st_own, code_unit_pkg::st_st_arb_own,
            code_unit_pkg::st_st_data_ack, code_unit_pkg::st_st_data_nack,
            code_unit_pkg::st_st_last_ack});
    endfunction

    function automatic logic in_gc(input code_unit_pkg::state_t s);
        in_gc = (s inside {code_unit_pkg::st_sr_gc, code_unit_pkg::st_sr_arb_gc,
            code_unit_pkg::st_sr_gc_data_ack, code_unit_pkg::st_sr_gc_data_nack});
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // crossing: link events in, control levels out

    code_unit_pkg::link_event_t ev_hold;
    logic ev_toggle;
    logic tog_s;
    logic tog_seen_q;
    logic [3:0] to_link;
    logic link_nrst;
    logic aa_link;
    logic en_q;
    logic begin_q;
    logic end_q;
    logic aa_q;
    code_unit_pkg::state_t state_q;
    code_unit_pkg::state_t state_d;
    logic si_q;
    logic [7:0] code_q;

    link_event_port u_link (
        .link_clock(link_clock),
        .link_nrst(link_nrst),
        .ev_valid(link_ev_valid),
        .ev_in(link_ev),
        .ack_slot(link_ack_slot),
        .aa_level(aa_link),
        .ev_hold(ev_hold),
        .ev_toggle(ev_toggle),
        .sda_o(sda_o),
        .sda_oe(sda_oe)
    );

    level_sync #(.WIDTH(1)) u_tog_sync (
        .clock(clock),
        .in_level(ev_toggle),
        .out_level(tog_s)
    );
    level_sync #(.WIDTH(4)) u_ctl_sync (
        .clock(link_clock),
        .in_level({nrst, begin_q, end_q, aa_q}),
        .out_level(to_link)
    );
    assign link_nrst = to_link[3];
    assign begin_request_link = to_link[2];
    assign end_request_link = to_link[1];
    assign aa_link = to_link[0];
    // event word is held steady in the link domain long before the toggle lands here
    logic ev_take;
    assign ev_take = (tog_s != tog_seen_q) && en_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            tog_seen_q <= 1'b0;
        end else begin
            tog_seen_q <= tog_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // register port decode

    logic ctrl_wr;
    assign ctrl_wr = sfr.wr && (sfr.addr == `CTRL_ADDR);
    // writes to the code address fall through untouched, so the code cannot be corrupted
    logic sw_end_slave;
    assign sw_end_slave = ctrl_wr && sfr.wdata[`CTRL_END_BIT] && !ev_take
        && (is_slave(state_q) || state_q == code_unit_pkg::st_timeout
        || state_q == code_unit_pkg::st_bus_error);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr.rd && sfr.addr == `CTRL_ADDR) begin
            sfr_rdata <= {state_q != code_unit_pkg::st_idle, en_q, begin_q, end_q,
                si_q, aa_q, 2'b00};
        end else if (sfr.rd && sfr.addr == `CODE_ADDR) begin
            sfr_rdata <= code_q;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // control bits

    always_ff @(posedge clock) begin
        if (!nrst) begin
            en_q <= 1'(`CTRL_RESET >> `CTRL_EN_BIT);
            aa_q <= 1'b0;
            begin_q <= 1'b0;
        end else if (ctrl_wr) begin
            en_q <= sfr.wdata[`CTRL_EN_BIT];
            aa_q <= sfr.wdata[`CTRL_AA_BIT];
            begin_q <= sfr.wdata[`CTRL_BEGIN_BIT];
        end
    end

    // a received STOP clears the end request; that clear beats a write in the same cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            end_q <= 1'b0;
        end else if (ev_take && ev_hold.kind == code_unit_pkg::ev_stop_seen) begin
            end_q <= 1'b0;
        end else if (sw_end_slave) begin
            end_q <= 1'b0;
        end else if (ctrl_wr) begin
            end_q <= sfr.wdata[`CTRL_END_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // protocol state

    always_comb begin
        state_d = state_q;
        if (!en_q) begin
            state_d = code_unit_pkg::st_idle;
        end else if (ev_take) begin
            case (ev_hold.kind)
                code_unit_pkg::ev_start_sent: state_d = code_unit_pkg::st_start;
                code_unit_pkg::ev_rstart_sent: state_d = code_unit_pkg::st_rstart;
                code_unit_pkg::ev_addr_sent: begin
                    if (ev_hold.read) begin
                        state_d = ev_hold.ack ? code_unit_pkg::st_mr_sla_ack
                            : code_unit_pkg::st_mr_sla_nack;
                    end else begin
                        state_d = ev_hold.ack ? code_unit_pkg::st_mt_sla_ack
                            : code_unit_pkg::st_mt_sla_nack;
                    end
                end
                code_unit_pkg::ev_data_sent: begin
                    if (is_master(state_q)) begin
                        state_d = ev_hold.ack ? code_unit_pkg::st_mt_data_ack
                            : code_unit_pkg::st_mt_data_nack;
                    end else if (!ev_hold.ack) begin
                        state_d = code_unit_pkg::st_st_data_nack;
                    end else if (aa_q) begin
                        state_d = code_unit_pkg::st_st_data_ack;
                    end else begin
                        state_d = code_unit_pkg::st_st_last_ack;
                    end
                end
                code_unit_pkg::ev_data_recv: begin
                    // ack here is what this end returned, steered by the ack flag
                    if (is_master(state_q)) begin
                        state_d = ev_hold.ack ? code_unit_pkg::st_mr_data_ack
                            : code_unit_pkg::st_mr_data_nack;
                    end else if (in_gc(state_q)) begin
                        state_d = ev_hold.ack ? code_unit_pkg::st_sr_gc_data_ack
                            : code_unit_pkg::st_sr_gc_data_nack;
                    end else begin
                        state_d = ev_hold.ack ? code_unit_pkg::st_sr_data_ack
                            : code_unit_pkg::st_sr_data_nack;
                    end
                end
                code_unit_pkg::ev_arb_lost: begin
                    case (ev_hold.match)
                        code_unit_pkg::m_own: state_d = ev_hold.read
                            ? code_unit_pkg::st_st_arb_own : code_unit_pkg::st_sr_arb_own;
                        code_unit_pkg::m_gc: state_d = code_unit_pkg::st_sr_arb_gc;
                        default: state_d = code_unit_pkg::st_arb_lost;
                    endcase
                end
                code_unit_pkg::ev_addressed: begin
                    if (ev_hold.match == code_unit_pkg::m_gc) begin
                        state_d = code_unit_pkg::st_sr_gc;
                    end else if (ev_hold.read) begin
                        state_d = code_unit_pkg::st_st_own;
                    end else begin
                        state_d = code_unit_pkg::st_sr_own;
                    end
                end
                code_unit_pkg::ev_stop_seen: begin
                    state_d = is_slave(state_q) ? code_unit_pkg::st_sr_stop
                        : code_unit_pkg::st_idle;
                end
                code_unit_pkg::ev_timeout: state_d = code_unit_pkg::st_timeout;
                code_unit_pkg::ev_bus_error: state_d = code_unit_pkg::st_bus_error;
                default: state_d = state_q;
            endcase
        end else if (sw_end_slave) begin
            state_d = code_unit_pkg::st_idle;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q <= code_unit_pkg::st_idle;
            code_q <= `CODE_RESET;
        end else begin
            state_q <= state_d;
            code_q <= code_of(state_d) & 8'hF8;
        end
    end

    // a set arriving with a software clear wins, so no event is lost
    always_ff @(posedge clock) begin
        if (!nrst) begin
            si_q <= 1'b0;
        end else if (ev_take && state_d != code_unit_pkg::st_idle) begin
            si_q <= 1'b1;
        end else if (ctrl_wr && !sfr.wdata[`CTRL_SI_BIT]) begin
            si_q <= 1'b0;
        end
    end
    assign serial_event = si_q;
    assign bus_condition_code = code_q;

    ////////////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_take(code_unit_pkg::ev_kind_t k);
        ev_take && en_q && ev_hold.kind == k;
    endsequence
    sequence s_slave_stop;
        s_take(code_unit_pkg::ev_stop_seen) ##0 is_slave(state_q);
    endsequence

    a_low_bits_zero: assert property (si_q |-> code_q[2:0] == 3'b000)
        else $error("low code bits not zero with flag set");
    a_code_flag_same: assert property (ev_take && state_d != code_unit_pkg::st_idle
        |=> si_q && code_q == code_of(state_q))
        else $error("code and flag not updated together");
    a_idle_no_flag: assert property (!si_q && ev_take && state_d == code_unit_pkg::st_idle
        |=> !si_q)
        else $error("idle entry set the flag");
    a_idle_code: assert property (state_q == code_unit_pkg::st_idle && $past(nrst)
        |-> code_q == 8'hF8)
        else $error("idle code wrong");
    a_start_code: assert property (s_take(code_unit_pkg::ev_start_sent)
        |=> code_q == 8'h08 && si_q)
        else $error("start code wrong");
    a_flag_sticky: assert property (si_q && !(ctrl_wr && !sfr.wdata[`CTRL_SI_BIT])
        |=> si_q)
        else $error("flag cleared without software");
    a_slave_stop: assert property (s_slave_stop |=> code_q == 8'hA0 ##1 si_q)
        else $error("slave stop code wrong");
    a_end_slave: assert property (sw_end_slave && en_q
        |=> state_q == code_unit_pkg::st_idle && !end_q)
        else $error("end request in slave mode not idle");
    a_arb_plain: assert property (s_take(code_unit_pkg::ev_arb_lost)
        ##0 ev_hold.match == code_unit_pkg::m_none |=> code_q == 8'h38)
        else $error("arbitration lost code wrong");
    a_bus_error: assert property (s_take(code_unit_pkg::ev_bus_error)
        |=> code_q == 8'h00 && si_q)
        else $error("bus error code wrong");
    a_timeout_code: assert property (s_take(code_unit_pkg::ev_timeout)
        |=> code_q == 8'hD0)
        else $error("timeout code wrong");
    a_code_tracks: assert property ($past(nrst) |-> code_q == code_of(state_q))
        else $error("code does not match state");

endmodule

`default_nettype wire

/* File: bus_agent.sv */
// far-side shift engine model: hands bus events and acknowledge slots to the unit
// assumes the unit samples its link inputs on the rising link clock edge
`timescale 1ns/1ps
`default_nettype none
module bus_agent (
    input wire logic link_clock,
    output logic ev_valid,
    output code_unit_pkg::link_event_t ev,
    output logic ack_slot
);
    initial begin
        ev_valid = 1'b0;
        ev = '0;
        ack_slot = 1'b0;
    end
    // one-cycle pulse, then idle edges so events stay apart
    task automatic send(input code_unit_pkg::link_event_t e);
        @(posedge link_clock) #1;
        ev_valid = 1'b1;
        ev = e;
        @(posedge link_clock) #1;
        ev_valid = 1'b0;
        ev = ~e; // a released word must not look valid
        repeat (3) @(posedge link_clock);
    endtask
    task automatic slot(input logic on);
        @(posedge link_clock) #1;
        ack_slot = on;
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the condition code unit
// assumes the unit, its package and the bus_agent model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic link_clock = 1'b0;
    code_unit_pkg::sfr_req_t sfr = '0;
    logic [7:0] sfr_rdata, code, rd;
    logic sda_o, sda_oe, serial_event, ev_valid, ack_slot, begin_link, end_link;
    code_unit_pkg::link_event_t ev;
    int miscompares = 0;
    int checked = 0;
    int n;
    // {aa, event word, expected code}; kind F means a software end request
    logic [19:0] rows [42] = '{
        20'h10008, 20'h11010, 20'h12818, 20'h12020,
        20'h13828, 20'h13030, 20'h15038, 20'h19000, 20'h1F0F8,
        20'h10008, 20'h12C40, 20'h12448, 20'h14850, 20'h04058,
        20'h180D0, 20'h1F0F8, 20'h16160, 20'h14980, 20'h14188, 20'h1F0F8,
        20'h16270, 20'h14A90, 20'h14298, 20'h170A0, 20'h19000, 20'h1F0F8,
        20'h165A8, 20'h138B8, 20'h130C0, 20'h1F0F8, 20'h165A8, 20'h038C8,
        20'h0F0F8, 20'h15168, 20'h19000, 20'h1F0F8, 20'h15278, 20'h19000,
        20'h1F0F8, 20'h155B0, 20'h19000, 20'h1F0F8};
    initial forever #5 clock = ~clock;
    initial begin
        #7;
        forever #24 link_clock = ~link_clock;
    end
    bus_agent bus (.link_clock(link_clock), .ev_valid(ev_valid), .ev(ev), .ack_slot(ack_slot));
    condition_code_unit DUT (.clock(clock), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .link_clock(link_clock), .link_ev_valid(ev_valid), .link_ev(ev),
        .link_ack_slot(ack_slot), .sda_o(sda_o), .sda_oe(sda_oe),
        .begin_request_link(begin_link), .end_request_link(end_link),
        .serial_event(serial_event), .bus_condition_code(code));
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clock) #1;
        sfr = {a, w, ~w, d};
        @(posedge clock) #1;
        sfr = '0;
        rd = sfr_rdata;
    endtask
    // control write always clears the event flag first
    task automatic run(input logic [19:0] r);
        acc(8'hC0, 1'b1, {3'b010, r[15:12] == 4'hF, 1'b0, r[16], 2'b00});
        n = 0;
        if (r[15:12] != 4'hF)
            bus.send(r[15:8]);
        while (serial_event !== 1'b1 && n < 40) begin
            @(posedge clock) #1;
            n++;
        end
        cmp("code", r[7:0], code);
        cmp("flag", {7'h00, r[15:12] != 4'hF}, {7'h00, serial_event});
        acc(8'hC1, 1'b0, 8'h00);
        cmp("code read", r[7:0], rd);
        repeat ($urandom_range(3)) @(posedge clock);
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        n = $urandom(71);
        repeat (15) @(posedge clock);
        #1;
        nrst = 1'b1;
        cmp("reset code", 8'h00, code);
        repeat (4) @(posedge link_clock);
        foreach (rows[i]) run(rows[i]);
        bus.slot(1'b1);
        repeat (4) @(posedge link_clock);
        cmp("ack drive", 8'h01, {7'h00, sda_oe});
        cmp("ack level", 8'h00, {7'h00, sda_o});
        acc(8'hC0, 1'b1, 8'h40);
        repeat (4) @(posedge link_clock);
        cmp("nack drive", 8'h00, {7'h00, sda_oe});
        bus.slot(1'b0);
        acc(8'hC0, 1'b1, 8'h70);
        acc(8'hC0, 1'b0, 8'h00);
        cmp("control read", 8'h70, rd);
        repeat (3) @(posedge link_clock);
        cmp("begin to link", 8'h01, {7'h00, begin_link});
        cmp("end to link", 8'h01, {7'h00, end_link});
        bus.send(8'h70);
        cmp("end cleared", 8'h00, {7'h00, end_link});
        cmp("idle flag", 8'h00, {7'h00, serial_event});
        repeat (8) begin
            acc(8'($urandom_range(8'hBF)), 1'b0, 8'h00);
            cmp("unmapped", 8'h00, rd);
        end
        print_verdict();
    end
    initial begin
        #300000;
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
